// *** core/sidsp_pkg.sv ***
// Shared constants and carrier types for the separate-I/O DDR SRAM port
package sidsp_pkg;

    // Configuration of the data path: four lanes of nine bits each
    localparam int SIDSP_LANES = 4;
    localparam int SIDSP_LANE_W = 9;
    localparam int SIDSP_DATA_W = SIDSP_LANES * SIDSP_LANE_W;

    // Burst address width per configuration
    localparam int SIDSP_ADDR_W_X8 = 20;
    localparam int SIDSP_ADDR_W_X9 = 20;
    localparam int SIDSP_ADDR_W_X18 = 19;
    localparam int SIDSP_ADDR_W_X36 = 18;
    localparam int SIDSP_ADDR_W = SIDSP_ADDR_W_X36;

    // Burst shape: four words, one per sub-array
    localparam int SIDSP_BURST = 4;
    localparam int SIDSP_BEAT_W = 2;
    localparam logic [SIDSP_BEAT_W-1:0] SIDSP_BEAT_FIRST = 2'h0;
    localparam logic [SIDSP_BEAT_W-1:0] SIDSP_BEAT_LAST = 2'h3;

    // Read data buffer depth in words
    localparam int SIDSP_FIFO_DEPTH = 8;

    // Highest rate allowed with the PLL off, and the core rate
    localparam int SIDSP_PLL_OFF_MAX_MHZ = 167;
    localparam int SIDSP_CORE_CLK_MHZ = 10;

    // Reset values of the pin-facing registers
    localparam logic SIDSP_OE_N_RST = 1'b1;
    localparam logic [SIDSP_DATA_W-1:0] SIDSP_Q_RST = 36'h0;

    // One write beat heading for the array
    typedef struct packed {
        logic we;
        logic [SIDSP_ADDR_W-1:0] addr;
        logic [SIDSP_BEAT_W-1:0] beat;
        logic [SIDSP_LANES-1:0] lane_en;
        logic [SIDSP_DATA_W-1:0] data;
    } sidsp_wr_t;

    // One read word in the buffer, tagged with burst start
    typedef struct packed {
        logic first;
        logic [SIDSP_DATA_W-1:0] data;
    } sidsp_rd_t;

    // Engine states
    typedef enum logic [1:0] {
        SIDSP_W_IDLE = 2'b01,
        SIDSP_W_DATA = 2'b10
    } sidsp_wr_state_t;

    typedef enum logic [1:0] {
        SIDSP_R_IDLE = 2'b01,
        SIDSP_R_FETCH = 2'b10
    } sidsp_rd_state_t;

    typedef enum logic [1:0] {
        SIDSP_O_OFF = 2'b01,
        SIDSP_O_DRIVE = 2'b10
    } sidsp_out_state_t;

endpackage

// *** core/sidsp_fifo.sv ***
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sidsp_fifo
    import sidsp_pkg::*;
#(
    parameter int W = 37,
    parameter int DEPTH = SIDSP_FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wptr_q, wptr_d;
    logic [PW-1:0] rptr_q, rptr_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic push, pop;

    // Honest full and empty from the word count
    assign in_ready_o = (cnt_q != CW'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rptr_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointer and count update
    always_comb
    begin
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        cnt_d = cnt_q;
        if (push)
        begin
            wptr_d = (wptr_q == PW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
        end
        if (pop)
        begin
            rptr_d = (rptr_q == PW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
        end
        if (push && !pop)
        begin
            cnt_d = cnt_q + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Pointer registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_q[wptr_q] <= in_data_i;
        end
    end

endmodule // sidsp_fifo

`default_nettype wire

// *** core/sidsp_array.sv ***
// Four-sub-array storage with per-lane write masking
`timescale 1ns/1ps
`default_nettype none

module sidsp_array
    import sidsp_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Write beat
    input wire sidsp_wr_t wr_i,
    // Read port, combinational
    input wire logic [SIDSP_ADDR_W-1:0] rd_addr_i,
    input wire logic [SIDSP_BEAT_W-1:0] rd_beat_i,
    output logic [SIDSP_DATA_W-1:0] rd_data_o
);

    localparam int IW = SIDSP_ADDR_W + SIDSP_BEAT_W;

    logic [IW-1:0] wr_idx, rd_idx;

    // Beat selects the sub-array, address the word inside it
    assign wr_idx = {wr_i.addr, wr_i.beat};
    assign rd_idx = {rd_addr_i, rd_beat_i};

    // One storage column per lane; disabled lanes keep their bits
    for (genvar l = 0; l < SIDSP_LANES; l++)
    begin : g_lane
        logic [SIDSP_LANE_W-1:0] mem_q [2**IW];

        always_ff @(posedge clk_i)
        begin
            if (wr_i.we && wr_i.lane_en[l]) // RULE6 RULE7 RULE9
            begin
                mem_q[wr_idx] <= wr_i.data[l*SIDSP_LANE_W +: SIDSP_LANE_W];
            end
        end

        assign rd_data_o[l*SIDSP_LANE_W +: SIDSP_LANE_W] = mem_q[rd_idx];
    end

endmodule // sidsp_array

`default_nettype wire

// *** core/sidsp_top.sv ***
// Pin-level core of a separate-I/O DDR SRAM with four-word bursts
//
// Contract
// RULE1: write data captured on every input edge
// RULE2: low write select on K starts write
// RULE3: high write select ignores write data
// RULE4: nibble enables cover bits 3:0 and 7:4; no nibble enables here, each enable covers a nine-bit lane
// RULE5: nibble enable sampled with beat, masks write; only the nine-bit byte enables are sampled here
// RULE6: byte enables cover nine-bit lanes
// RULE7: byte enable sampled with beat, masks write
// RULE8: shared address sampled on K edges
// RULE9: four sub-arrays, one per burst word
// RULE10: address ignored for deselected port
// RULE11: read data driven only during reads
// RULE12: read beats on output edges, single-clock on K
// RULE13: low read select on K starts read
// RULE14: deselect: finish, tristate after next C edge
// RULE15: each read gives four sequential words
// RULE16: output clocks time the read data
// RULE17: PLL off selects one-cycle read latency
// RULE18: echo strobe follows output or input clock
// RULE19: write burst is four beats, each masked
`timescale 1ns/1ps
`default_nettype none

module sidsp_top
    import sidsp_pkg::*;
#(
    parameter int FIFO_DEPTH = SIDSP_FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    // Input clock phase: high on a positive input edge
    input wire logic K_POS_I,
    // Output clock edge strobe and phase
    input wire logic C_EDGE_I,
    input wire logic C_POS_I,
    // Mode pins
    input wire logic SINGLE_CLK_I,
    input wire logic PLL_DISABLE_N_I,
    // Shared address and port selects
    input wire logic [SIDSP_ADDR_W-1:0] ADDR_I,
    input wire logic WRITE_PORT_SEL_N_I,
    input wire logic READ_PORT_SEL_N_I,
    // Write data and lane enables
    input wire logic [SIDSP_LANES-1:0] BYTE_ENABLE_N_I,
    input wire logic [SIDSP_DATA_W-1:0] WDATA_I,
    // Read data and its driver enable
    output logic [SIDSP_DATA_W-1:0] Q_O,
    output logic Q_OE_N_O,
    // Echo strobes
    output logic ECHO_STROBE_O,
    output logic ECHO_STROBE_N_O
);

    localparam int RD_W = $bits(sidsp_rd_t);

    // Write engine state
    sidsp_wr_state_t wr_state_q, wr_state_d;
    logic [SIDSP_ADDR_W-1:0] wr_addr_q, wr_addr_d;
    logic [SIDSP_BEAT_W-1:0] wr_beat_q, wr_beat_d;
    sidsp_wr_t wr_beat;
    logic wr_take;

    // Read engine state
    sidsp_rd_state_t rd_state_q, rd_state_d;
    logic [SIDSP_ADDR_W-1:0] rd_addr_q, rd_addr_d;
    logic [SIDSP_BEAT_W-1:0] rd_beat_q, rd_beat_d;
    logic [SIDSP_DATA_W-1:0] rd_word;
    logic rd_take;
    logic rd_push;
    sidsp_rd_t rd_in;
    logic rd_ready;

    // Output stage state
    sidsp_out_state_t out_state_q, out_state_d;
    logic [SIDSP_DATA_W-1:0] q_q, q_d;
    logic oe_n_q, oe_n_d;
    logic echo_q, echo_d;
    logic echo_n_q, echo_n_d;
    logic [RD_W-1:0] fifo_out;
    sidsp_rd_t rd_out;
    logic rd_valid;
    logic out_edge, out_pos, first_ok, launch;

    // Select sampling happens only on positive input edges
    assign wr_take = K_POS_I && !WRITE_PORT_SEL_N_I; // RULE2 RULE8 RULE10
    assign rd_take = K_POS_I && !READ_PORT_SEL_N_I; // RULE13 RULE8 RULE10

    // Write beat toward the array, one per input edge
    always_comb
    begin
        wr_beat.we = (wr_state_q == SIDSP_W_DATA); // RULE1 RULE3
        wr_beat.addr = wr_addr_q;
        wr_beat.beat = wr_beat_q; // RULE9
        wr_beat.lane_en = ~BYTE_ENABLE_N_I; // RULE7 RULE19
        wr_beat.data = WDATA_I;
    end

    // Write engine next state
    always_comb
    begin
        wr_state_d = wr_state_q;
        wr_addr_d = wr_addr_q;
        wr_beat_d = wr_beat_q;
        case (wr_state_q)
            SIDSP_W_IDLE:
            begin
                if (wr_take)
                begin
                    wr_state_d = SIDSP_W_DATA;
                    wr_addr_d = ADDR_I; // RULE8
                    wr_beat_d = SIDSP_BEAT_FIRST;
                end
            end
            SIDSP_W_DATA:
            begin
                wr_beat_d = wr_beat_q + 1'b1; // RULE19
                if (wr_beat_q == SIDSP_BEAT_LAST)
                begin
                    // Last beat lands on a K edge; a new write may start there
                    if (wr_take)
                    begin
                        wr_addr_d = ADDR_I;
                        wr_beat_d = SIDSP_BEAT_FIRST;
                    end
                    else
                    begin
                        wr_state_d = SIDSP_W_IDLE; // RULE3
                    end
                end
            end
            default:
            begin
                wr_state_d = SIDSP_W_IDLE;
            end
        endcase
    end

    // Write engine registers
    always_ff @(posedge CORE_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            wr_state_q <= SIDSP_W_IDLE;
            wr_addr_q <= '0;
            wr_beat_q <= SIDSP_BEAT_FIRST;
        end
        else
        begin
            wr_state_q <= wr_state_d;
            wr_addr_q <= wr_addr_d;
            wr_beat_q <= wr_beat_d;
        end
    end

    // Storage
    sidsp_array u_array (
        .clk_i(CORE_CLK_I),
        .wr_i(wr_beat),
        .rd_addr_i(rd_addr_q),
        .rd_beat_i(rd_beat_q),
        .rd_data_o(rd_word)
    );

    // Read words enter the buffer while fetching and room remains
    assign rd_push = (rd_state_q == SIDSP_R_FETCH) && rd_ready;
    assign rd_in.first = (rd_beat_q == SIDSP_BEAT_FIRST);
    assign rd_in.data = rd_word;

    // Read engine next state; stalls when the buffer is full
    always_comb
    begin
        rd_state_d = rd_state_q;
        rd_addr_d = rd_addr_q;
        rd_beat_d = rd_beat_q;
        case (rd_state_q)
            SIDSP_R_IDLE:
            begin
                if (rd_take)
                begin
                    rd_state_d = SIDSP_R_FETCH;
                    rd_addr_d = ADDR_I; // RULE8
                    rd_beat_d = SIDSP_BEAT_FIRST;
                end
            end
            SIDSP_R_FETCH:
            begin
                if (rd_push)
                begin
                    rd_beat_d = rd_beat_q + 1'b1; // RULE15
                    if (rd_beat_q == SIDSP_BEAT_LAST)
                    begin
                        if (rd_take)
                        begin
                            rd_addr_d = ADDR_I;
                            rd_beat_d = SIDSP_BEAT_FIRST;
                        end
                        else
                        begin
                            rd_state_d = SIDSP_R_IDLE;
                        end
                    end
                end
            end
            default:
            begin
                rd_state_d = SIDSP_R_IDLE;
            end
        endcase
    end

    // Read engine registers
    always_ff @(posedge CORE_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            rd_state_q <= SIDSP_R_IDLE;
            rd_addr_q <= '0;
            rd_beat_q <= SIDSP_BEAT_FIRST;
        end
        else
        begin
            rd_state_q <= rd_state_d;
            rd_addr_q <= rd_addr_d;
            rd_beat_q <= rd_beat_d;
        end
    end

    // Read data buffer between array and output pins
    sidsp_fifo #(
        .W(RD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .in_valid_i(rd_push),
        .in_ready_o(rd_ready),
        .in_data_i(rd_in),
        .out_valid_o(rd_valid),
        .out_ready_i(launch),
        .out_data_o(fifo_out)
    );

    assign rd_out = sidsp_rd_t'(fifo_out);

    // Output timing source: C clocks, or K clocks in single-clock mode
    assign out_edge = SINGLE_CLK_I ? 1'b1 : C_EDGE_I; // RULE12 RULE16
    assign out_pos = SINGLE_CLK_I ? K_POS_I : C_POS_I; // RULE12
    // PLL on: burst opens on a negative edge; off: on a positive edge
    assign first_ok = PLL_DISABLE_N_I ? !out_pos : out_pos; // RULE17
    assign launch = out_edge && rd_valid && (!rd_out.first || first_ok); // RULE12

    // Output stage next state
    always_comb
    begin
        out_state_d = out_state_q;
        q_d = q_q;
        oe_n_d = oe_n_q;
        case (out_state_q)
            SIDSP_O_OFF:
            begin
                if (launch)
                begin
                    q_d = rd_out.data;
                    oe_n_d = 1'b0; // RULE11
                    out_state_d = SIDSP_O_DRIVE;
                end
            end
            SIDSP_O_DRIVE:
            begin
                if (launch)
                begin
                    q_d = rd_out.data; // RULE15
                end
                else if (out_edge && out_pos)
                begin
                    // Burst done: release the pins at the next positive edge
                    oe_n_d = 1'b1; // RULE14 RULE11
                    out_state_d = SIDSP_O_OFF;
                end
            end
            default:
            begin
                oe_n_d = 1'b1;
                out_state_d = SIDSP_O_OFF;
            end
        endcase
    end

    // Echo strobes follow the output timing source every cycle
    always_comb
    begin
        echo_d = out_pos; // RULE18
        echo_n_d = !out_pos;
    end

    // Output stage registers
    always_ff @(posedge CORE_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            out_state_q <= SIDSP_O_OFF;
            q_q <= SIDSP_Q_RST;
            oe_n_q <= SIDSP_OE_N_RST;
            echo_q <= 1'b0;
            echo_n_q <= 1'b1;
        end
        else
        begin
            out_state_q <= out_state_d;
            q_q <= q_d;
            oe_n_q <= oe_n_d;
            echo_q <= echo_d;
            echo_n_q <= echo_n_d;
        end
    end

    // Pin drivers
    assign Q_O = q_q;
    assign Q_OE_N_O = oe_n_q;
    assign ECHO_STROBE_O = echo_q;
    assign ECHO_STROBE_N_O = echo_n_q;

endmodule // sidsp_top

`default_nettype wire

// *** bench/sidsp_checker.sv ***
// Pin-level assertions for the separate-I/O DDR SRAM port
`timescale 1ns/1ps
`default_nettype none

module sidsp_checker
    import sidsp_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    // Clock phases and mode
    input wire logic K_POS_I,
    input wire logic C_EDGE_I,
    input wire logic C_POS_I,
    input wire logic SINGLE_CLK_I,
    input wire logic READ_PORT_SEL_N_I,
    // Watched outputs
    input wire logic [SIDSP_DATA_W-1:0] Q_O,
    input wire logic Q_OE_N_O,
    input wire logic ECHO_STROBE_O,
    input wire logic ECHO_STROBE_N_O
);
    // Any output edge, and a positive one, in this cycle
    wire logic out_edge = SINGLE_CLK_I || C_EDGE_I;
    wire logic pos_edge = SINGLE_CLK_I ? K_POS_I : (C_EDGE_I && C_POS_I);

    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    a_echo_out_clk: assert property (!SINGLE_CLK_I |=> ECHO_STROBE_O == $past(C_POS_I))
        else $error("echo strobe does not follow output clock");
    a_echo_in_clk: assert property (SINGLE_CLK_I |=> ECHO_STROBE_O == $past(K_POS_I))
        else $error("echo strobe does not follow input clock");
    a_echo_pair: assert property (ECHO_STROBE_N_O != ECHO_STROBE_O)
        else $error("echo strobes not complementary");
    a_read_start: assert property (SINGLE_CLK_I && K_POS_I && !READ_PORT_SEL_N_I && Q_OE_N_O
        |-> ##[1:4] !Q_OE_N_O)
        else $error("read select did not start output");
    a_drive_on_edge: assert property ($fell(Q_OE_N_O)
        |-> $past(out_edge) || $past(out_edge, 2))
        else $error("output driver enabled without output edge");
    a_burst_four: assert property ($fell(Q_OE_N_O) |-> !Q_OE_N_O [*4])
        else $error("read burst shorter than four words");
    a_tristate_pos: assert property ($rose(Q_OE_N_O)
        |-> $past(pos_edge) || $past(pos_edge, 2))
        else $error("output released without positive output edge");
    a_q_launch: assert property (!$stable(Q_O)
        |-> $past(out_edge) || $past(out_edge, 2))
        else $error("read data changed without output edge");
endmodule // sidsp_checker

bind sidsp_top sidsp_checker u_chk (.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I),
    .K_POS_I(K_POS_I), .C_EDGE_I(C_EDGE_I), .C_POS_I(C_POS_I), .SINGLE_CLK_I(SINGLE_CLK_I),
    .READ_PORT_SEL_N_I(READ_PORT_SEL_N_I), .Q_O(Q_O), .Q_OE_N_O(Q_OE_N_O),
    .ECHO_STROBE_O(ECHO_STROBE_O), .ECHO_STROBE_N_O(ECHO_STROBE_N_O));

`default_nettype wire

// *** bench/sidsp_ctrl_model.sv ***
// Controller model: input and output clock phases toward the port
`timescale 1ns/1ps
`default_nettype none

module sidsp_ctrl_model
(
    // Clock, reset and output clock stall
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    // Clock phases toward the port
    output logic k_pos_o,
    output logic c_edge_o,
    output logic c_pos_o
);
    logic k_q = 1'b1;
    logic c_edge_q = 1'b0;

    // K and K-bar alternate; C follows K unless held still
    always @(posedge clk_i)
    begin
        k_q <= rst_i ? 1'b1 : !k_q;
        c_edge_q <= !stall_i;
    end
    assign k_pos_o = k_q;
    assign c_edge_o = c_edge_q;
    assign c_pos_o = k_q;
endmodule // sidsp_ctrl_model

`default_nettype wire

// *** bench/test_sep_io_ddr_sram_port.sv ***
// Self-checking bench for the separate-I/O DDR SRAM port
`timescale 1ns/1ps
`default_nettype none

module test_sep_io_ddr_sram_port;
    import sidsp_pkg::*;

    // Pins, model memory and read capture
    logic clk, rst, k_pos, c_edge, c_pos, stall, single, pll_n, wsel_n, rsel_n;
    logic oe_n, echo, echo_n, oe_was;
    logic [SIDSP_ADDR_W-1:0] addr;
    logic [SIDSP_LANES-1:0] be_n;
    logic [SIDSP_DATA_W-1:0] wdata, q, last_q;
    logic [SIDSP_DATA_W-1:0] mem [int];
    logic [SIDSP_DATA_W-1:0] rxq [$];
    logic [SIDSP_DATA_W-1:0] expq [$];
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;

    sidsp_ctrl_model u_ctrl (.clk_i(clk), .rst_i(rst), .stall_i(stall), .k_pos_o(k_pos),
        .c_edge_o(c_edge), .c_pos_o(c_pos));

    sidsp_top u_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .K_POS_I(k_pos), .C_EDGE_I(c_edge),
        .C_POS_I(c_pos), .SINGLE_CLK_I(single), .PLL_DISABLE_N_I(pll_n), .ADDR_I(addr),
        .WRITE_PORT_SEL_N_I(wsel_n), .READ_PORT_SEL_N_I(rsel_n), .BYTE_ENABLE_N_I(be_n),
        .WDATA_I(wdata), .Q_O(q), .Q_OE_N_O(oe_n), .ECHO_STROBE_O(echo),
        .ECHO_STROBE_N_O(echo_n));

    // Clock and cycle ceiling
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    // Collect each new word while the port drives
    always @(negedge clk)
    begin
        if (!oe_n && (oe_was || q !== last_q))
            rxq.push_back(q);
        last_q = q;
        oe_was = oe_n;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [SIDSP_DATA_W-1:0] exp, got);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    // Wait until the next edge is a K edge
    task automatic align;
        while (k_pos !== 1'b1)
            tick();
    endtask

    // Write burst: four beats after the select, lane masks per beat
    task automatic wr_burst(input logic [SIDSP_ADDR_W-1:0] a, input logic [SIDSP_DATA_W-1:0] b,
        input logic [15:0] bes, input logic sel_n);
        align();
        wsel_n = sel_n;
        addr = a;
        tick();
        wsel_n = 1'b1;
        addr = ~a;
        for (int i = 0; i < 4; i++)
        begin
            wdata = b + i;
            be_n = bes[4*i +: 4];
            for (int l = 0; l < SIDSP_LANES; l++)
                if (!sel_n && !be_n[l])
                    mem[a*4+i][SIDSP_LANE_W*l +: SIDSP_LANE_W] =
                        wdata[SIDSP_LANE_W*l +: SIDSP_LANE_W];
            tick();
        end
        be_n = 4'hf;
        wdata = ~wdata;
    endtask

    // Read select; expected words queued in burst order
    task automatic rd_sel(input logic [SIDSP_ADDR_W-1:0] a);
        align();
        rsel_n = 1'b0;
        addr = a;
        for (int i = 0; i < 4; i++)
            expq.push_back(mem[a*4+i]);
        tick();
        rsel_n = 1'b1;
        addr = ~a;
    endtask

    // Wait for all words, allow stray extras to show, then compare
    task automatic drain(input string what);
        for (int n = 0; n < 40 && rxq.size() < expq.size(); n++)
            tick();
        repeat (6) tick();
        check("word count", expq.size(), rxq.size());
        foreach (expq[i])
            check(what, expq[i], rxq[i]);
        rxq.delete();
        expq.delete();
    endtask

    task automatic t_reset;
        check("driver enable", 1'b1, oe_n);
        check("echo pair", 2'b01, {echo, echo_n});
    endtask

    task automatic t_masked_write;
        wr_burst(18'h00012, 36'h123456789, 16'h0000, 1'b0);
        wr_burst(18'h00012, 36'h0abcdef00, 16'h7bde, 1'b0);
        rd_sel(18'h00012);
        drain("masked burst");
    endtask

    task automatic t_deselect;
        wr_burst(18'h00012, 36'h555555555, 16'h0000, 1'b1);
        rd_sel(18'h00012);
        drain("deselected write");
    endtask

    // Second write select rides on the last beat of the first
    task automatic t_write_chain;
        align();
        wsel_n = 1'b0;
        addr = 18'h00040;
        tick();
        be_n = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            wsel_n = (i == 3) ? 1'b0 : 1'b1;
            addr = (i == 3) ? 18'h00041 : 18'h00000;
            wdata = 36'h0f0f0f0f0 + i;
            mem[((i < 4) ? 18'h00040 : 18'h00041)*4 + i%4] = wdata;
            tick();
        end
        wsel_n = 1'b1;
        be_n = 4'hf;
        rd_sel(18'h00040);
        tick();
        tick();
        rd_sel(18'h00041);
        drain("chained write");
    endtask

    task automatic t_back_to_back;
        single = 1'b0;
        wr_burst(18'h3ff00, 36'h9a0b1c2d0, 16'h0000, 1'b0);
        for (int m = 0; m < 2; m++)
        begin
            pll_n = m[0];
            rd_sel(18'h00012);
            tick();
            tick();
            rd_sel(18'h3ff00);
            drain("back to back");
        end
    endtask

    task automatic t_fifo_full;
        stall = 1'b1;
        rd_sel(18'h3ff00);
        tick();
        tick();
        rd_sel(18'h00012);
        tick();
        tick();
        rd_sel(18'h3ff00);
        repeat (12) tick();
        check("held driver", 1'b1, oe_n);
        stall = 1'b0;
        drain("full buffer");
    endtask

    initial
    begin
        rst = 1'b1;
        stall = 1'b0;
        single = 1'b1;
        pll_n = 1'b0;
        wsel_n = 1'b1;
        rsel_n = 1'b1;
        addr = '0;
        be_n = 4'hf;
        wdata = '0;
        oe_was = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_masked_write();
        t_deselect();
        t_write_chain();
        t_back_to_back();
        t_fifo_full();
        wrap_up();
    end
endmodule // test_sep_io_ddr_sram_port

`default_nettype wire
